//--- common/iswl_defs.svh
`ifndef IWL_DEFS_SVH
`define IWL_DEFS_SVH
`define IWL_W            16
`define IWL_BIT_ICONT    0
`define IWL_BIT_MERR     1
`define IWL_BIT_RETRY    2
`define IWL_BIT_POLL     3
`define IWL_BIT_ILLCMD   4
`define IWL_BIT_ILLBC    5
`define IWL_BIT_MCNODATA 6
`define IWL_BIT_SAEVT    7
`define IWL_BIT_RSVD     8
`define IWL_BIT_TERR     9
`define IWL_BIT_NORESP   10
`define IWL_BIT_ACC      11
`define IWL_ZERO_W       16'h0000
`define IWL_IDX_W        8
`define IWL_IDX_ZERO     8'h00
`define IWL_WORDS        2'h3
`define IWL_WCNT_ZERO    2'h0
`define IWL_WCNT_ONE     2'h1
`define IWL_WCNT_TWO     2'h2
`define IWL_ADDR_ONE     16'h0001
`endif

//--- common/iwl_pkg.sv
package iwl_pkg;
  typedef enum logic [1:0] {
    IWL_IDLE  = 2'h0,
    IWL_WSTAT = 2'h1,
    IWL_WPTR  = 2'h3,
    IWL_RTAIL = 2'h2
  } iwl_state_t;
endpackage

//--- design/iwl_compose.sv
`timescale 1ns/1ns
`default_nettype none
`include "iswl_defs.svh"
module iwl_compose (
  input  wire logic                  rt_mode,
  input  wire logic                  msg_error,
  input  wire logic                  resp_timeout,
  input  wire logic                  sent_status_me,
  input  wire logic                  desc_access,
  input  wire logic                  valid_cmd_int_en,
  input  wire logic                  index_zero_int_en,
  input  wire logic [`IWL_IDX_W-1:0] index_after,
  input  wire logic                  mode_code_nodata,
  input  wire logic                  when_addressed_en,
  input  wire logic                  illegal_cmd,
  input  wire logic                  broadcast,
  input  wire logic                  receive_cmd,
  input  wire logic                  poll_match,
  input  wire logic                  retries_exhausted,
  input  wire logic                  int_and_continue,
  output logic      [`IWL_W-1:0]     status_word
);
  always_comb begin
    status_word                        = `IWL_ZERO_W; // R16
    status_word[`IWL_BIT_ACC]          = 1'b1; // R1
    status_word[`IWL_BIT_MERR]         = msg_error; // R11
    status_word[`IWL_BIT_NORESP]       = msg_error & resp_timeout; // R3
    status_word[`IWL_BIT_TERR]         = rt_mode & sent_status_me; // R4
    status_word[`IWL_BIT_SAEVT]        = rt_mode & desc_access & (valid_cmd_int_en |
      (index_zero_int_en & (index_after == `IWL_IDX_ZERO))); // R5
    status_word[`IWL_BIT_MCNODATA]     = rt_mode & mode_code_nodata & when_addressed_en; // R6
    status_word[`IWL_BIT_ILLBC]        = rt_mode & illegal_cmd & broadcast & receive_cmd; // R7
    status_word[`IWL_BIT_ILLCMD]       = rt_mode & illegal_cmd; // R8
    status_word[`IWL_BIT_POLL]         = ~rt_mode & poll_match; // R9
    status_word[`IWL_BIT_RETRY]        = ~rt_mode & retries_exhausted; // R10
    status_word[`IWL_BIT_ICONT]        = ~rt_mode & int_and_continue; // R12
  end
endmodule // iwl_compose
`default_nettype wire

//--- design/iwl_logger.sv
`timescale 1ns/1ns
`default_nettype none
`include "iswl_defs.svh"
//
// Contract
// R1: Written status word always has accessed set
// R2: Host may clear accessed; never re-set
// R3: Timeout error also sets no-response flag
// R4: RT sent status ME sets terminal error
// R5: Descriptor interrupt or index zero sets subaddress
// R6: Dataless mode code with enable sets flag
// R7: Illegal broadcast only for illegal broadcast receives
// R8: Illegal command flag; invalid commands excluded
// R9: BC polling match sets polling flag
// R10: Retry fail only after all retries fail
// R11: Any message error sets general error flag
// R12: BC interrupt-and-continue sets its flag
// R13: All flags active high
// R14: Record: status, pointer, tail read; enabled only
// R15: Pulse standard event once per occurrence
// R16: Fixed bit positions, reserved written zero
module iwl_logger (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  event_valid,
  input  wire logic                  event_enabled,
  input  wire logic [`IWL_W-1:0]     record_pointer,
  input  wire logic [`IWL_W-1:0]     log_start_addr,
  input  wire logic                  log_start_load,
  input  wire logic                  rt_mode,
  input  wire logic                  msg_error,
  input  wire logic                  resp_timeout,
  input  wire logic                  sent_status_me,
  input  wire logic                  desc_access,
  input  wire logic                  valid_cmd_int_en,
  input  wire logic                  index_zero_int_en,
  input  wire logic [`IWL_IDX_W-1:0] index_after,
  input  wire logic                  mode_code_nodata,
  input  wire logic                  when_addressed_en,
  input  wire logic                  illegal_cmd,
  input  wire logic                  broadcast,
  input  wire logic                  receive_cmd,
  input  wire logic                  poll_match,
  input  wire logic                  retries_exhausted,
  input  wire logic                  int_and_continue,
  input  wire logic                  mem_ack,
  input  wire logic [`IWL_W-1:0]     mem_rdata,
  output logic                       mem_req,
  output logic                       mem_write,
  output logic      [`IWL_W-1:0]     mem_addr,
  output logic      [`IWL_W-1:0]     mem_wdata,
  output logic                       busy,
  output logic      [`IWL_W-1:0]     log_addr,
  output logic                       standard_event_pulse
);
  logic [`IWL_W-1:0]   comp_word;
  iwl_pkg::iwl_state_t state;
  iwl_pkg::iwl_state_t next_state;
  logic                take;
  logic                word_done;
  logic [`IWL_W-1:0]   next_log_addr;
  logic [`IWL_W-1:0]   ptr_hold;
  logic [`IWL_W-1:0]   next_ptr_hold;
  logic                next_mem_req;
  logic                next_mem_write;
  logic [`IWL_W-1:0]   next_mem_addr;
  logic [`IWL_W-1:0]   next_mem_wdata;
  logic                next_busy;
  logic                next_pulse;

  // Address of one word inside the current record
  function automatic logic [`IWL_W-1:0] entry_addr(
    input logic [`IWL_W-1:0] base,
    input logic [1:0]        slot
  );
    entry_addr = base + {{(`IWL_W-2){1'b0}}, slot};
  endfunction

  iwl_compose u_compose (
    .rt_mode           (rt_mode),
    .msg_error         (msg_error),
    .resp_timeout      (resp_timeout),
    .sent_status_me    (sent_status_me),
    .desc_access       (desc_access),
    .valid_cmd_int_en  (valid_cmd_int_en),
    .index_zero_int_en (index_zero_int_en),
    .index_after       (index_after),
    .mode_code_nodata  (mode_code_nodata),
    .when_addressed_en (when_addressed_en),
    .illegal_cmd       (illegal_cmd),
    .broadcast         (broadcast),
    .receive_cmd       (receive_cmd),
    .poll_match        (poll_match),
    .retries_exhausted (retries_exhausted),
    .int_and_continue  (int_and_continue),
    .status_word       (comp_word)
  );

  // Event acceptance and word completion
  always_comb begin
    take      = (state == iwl_pkg::IWL_IDLE) && !log_start_load &&
                event_valid && event_enabled; // R14
    word_done = mem_req && mem_ack;
  end

  // Record sequencer
  always_comb begin
    next_state = state;
    case (state)
      iwl_pkg::IWL_IDLE: begin
        if (take) begin
          next_state = iwl_pkg::IWL_WSTAT;
        end
      end
      iwl_pkg::IWL_WSTAT: begin
        if (word_done) begin
          next_state = iwl_pkg::IWL_WPTR;
        end
      end
      iwl_pkg::IWL_WPTR: begin
        if (word_done) begin
          next_state = iwl_pkg::IWL_RTAIL;
        end
      end
      iwl_pkg::IWL_RTAIL: begin
        if (word_done) begin
          next_state = iwl_pkg::IWL_IDLE;
        end
      end
      default: begin
        next_state = iwl_pkg::IWL_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= iwl_pkg::IWL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Log address and record pointer
  always_comb begin
    next_log_addr = log_addr;
    next_ptr_hold = ptr_hold;
    if ((state == iwl_pkg::IWL_IDLE) && log_start_load) begin
      next_log_addr = log_start_addr;
    end
    if (take) begin
      next_ptr_hold = record_pointer;
    end
    if ((state == iwl_pkg::IWL_RTAIL) && word_done) begin
      next_log_addr = mem_rdata; // R14
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      log_addr <= `IWL_ZERO_W;
      ptr_hold <= `IWL_ZERO_W;
    end else begin
      log_addr <= next_log_addr;
      ptr_hold <= next_ptr_hold;
    end
  end

  // Memory word sequencing
  always_comb begin
    next_mem_req   = mem_req;
    next_mem_write = mem_write;
    next_mem_addr  = mem_addr;
    next_mem_wdata = mem_wdata;
    case (state)
      iwl_pkg::IWL_IDLE: begin
        if (take) begin
          next_mem_req   = 1'b1;
          next_mem_write = 1'b1;
          next_mem_addr  = log_addr;
          next_mem_wdata = comp_word; // R1 R13
        end
      end
      iwl_pkg::IWL_WSTAT: begin
        if (word_done) begin
          next_mem_addr  = entry_addr(log_addr, `IWL_WCNT_ONE);
          next_mem_wdata = ptr_hold; // R14
        end
      end
      iwl_pkg::IWL_WPTR: begin
        if (word_done) begin
          next_mem_write = 1'b0;
          next_mem_addr  = entry_addr(log_addr, `IWL_WCNT_TWO); // R14
          next_mem_wdata = `IWL_ZERO_W;
        end
      end
      iwl_pkg::IWL_RTAIL: begin
        if (word_done) begin
          next_mem_req = 1'b0;
        end
      end
      default: begin
        next_mem_req   = 1'b0;
        next_mem_write = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_req   <= 1'b0;
      mem_write <= 1'b0;
      mem_addr  <= `IWL_ZERO_W;
      mem_wdata <= `IWL_ZERO_W;
    end else begin
      mem_req   <= next_mem_req;
      mem_write <= next_mem_write;
      mem_addr  <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

  // Event pulse and busy flag
  always_comb begin
    next_pulse = (state == iwl_pkg::IWL_RTAIL) && word_done; // R15
    next_busy  = (next_state != iwl_pkg::IWL_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      standard_event_pulse <= 1'b0;
      busy                 <= 1'b0;
    end else begin
      standard_event_pulse <= next_pulse;
      busy                 <= next_busy;
    end
  end
endmodule // iwl_logger
`default_nettype wire

//--- dv/iwl_logger_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "iswl_defs.svh"
module iwl_logger_monitor (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        event_valid,
  input wire logic        event_enabled,
  input wire logic        log_start_load,
  input wire logic        rt_mode,
  input wire logic        msg_error,
  input wire logic        resp_timeout,
  input wire logic        sent_status_me,
  input wire logic        poll_match,
  input wire logic        retries_exhausted,
  input wire logic        broadcast,
  input wire logic        receive_cmd,
  input wire logic        mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        busy,
  input wire logic [15:0] log_addr,
  input wire logic        standard_event_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire tk = event_valid & event_enabled & !busy & !log_start_load;
  property p_acc; $rose(mem_req) |-> mem_wdata[`IWL_BIT_ACC]; endproperty
  a_acc: assert property (p_acc) else $error("accessed flag clear");
  property p_rsvd; $rose(mem_req) |-> !mem_wdata[`IWL_BIT_RSVD] && mem_wdata[15:12] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_first; $rose(mem_req) |-> mem_write && mem_addr == log_addr && $past(tk); endproperty
  a_first: assert property (p_first) else $error("bad first word");
  property p_noresp; tk && msg_error && resp_timeout |=> mem_wdata[`IWL_BIT_NORESP]; endproperty
  a_noresp: assert property (p_noresp) else $error("timeout flag missing");
  property p_merr; tk |=> mem_wdata[`IWL_BIT_MERR] == $past(msg_error); endproperty
  a_merr: assert property (p_merr) else $error("error flag wrong");
  property p_terr; tk && rt_mode |=> mem_wdata[`IWL_BIT_TERR] == $past(sent_status_me); endproperty
  a_terr: assert property (p_terr) else $error("terminal error flag wrong");
  property p_poll; tk && !rt_mode |=> mem_wdata[`IWL_BIT_POLL] == $past(poll_match)
    && mem_wdata[`IWL_BIT_RETRY] == $past(retries_exhausted); endproperty
  a_poll: assert property (p_poll) else $error("poll or retry flag wrong");
  property p_illbc; tk && !(broadcast && receive_cmd) |=> !mem_wdata[`IWL_BIT_ILLBC]; endproperty
  a_illbc: assert property (p_illbc) else $error("broadcast flag wrong");
  property p_done; mem_req && mem_ack && !mem_write |=> standard_event_pulse && !busy
    && log_addr == $past(mem_rdata) ##1 !standard_event_pulse; endproperty
  a_done: assert property (p_done) else $error("record end wrong");
  property p_off; event_valid && !event_enabled && !busy |=> !mem_req; endproperty
  a_off: assert property (p_off) else $error("disabled event logged");
  c_rt: cover property (tk && rt_mode);
  c_bc: cover property (tk && !rt_mode);
  c_pulse: cover property (standard_event_pulse);
endmodule // iwl_logger_monitor
bind iwl_logger iwl_logger_monitor u_mon (.core_clk, .rst, .event_valid, .event_enabled,
  .log_start_load, .rt_mode, .msg_error, .resp_timeout, .sent_status_me, .poll_match,
  .retries_exhausted, .broadcast, .receive_cmd, .mem_ack, .mem_rdata, .mem_req, .mem_write,
  .mem_addr, .mem_wdata, .busy, .log_addr, .standard_event_pulse);
`default_nettype wire

//--- dv/iwl_host_mem.sv
`timescale 1ns/1ns
`default_nettype none
`include "iswl_defs.svh"
module iwl_host_mem (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [3:0]  lag,
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic            mem_ack,
  output logic [15:0]     mem_rdata
);
  logic [3:0]  wait_cnt;
  logic [15:0] mem [0:255];
  always_ff @(posedge core_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst) begin
      wait_cnt <= 4'h0;
      mem_rdata <= 16'h0000;
    end else if (mem_req && !mem_ack) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt == lag) begin
        mem_ack <= 1'b1;
        wait_cnt <= 4'h0;
        if (mem_write) begin
          mem[mem_addr[7:0]] <= mem_wdata;
        end else begin
          mem_rdata <= mem_addr + 16'h0001;
          mem[mem_addr[7:0] - 8'h02][`IWL_BIT_ACC] <= 1'b0;
        end
      end
    end
  end
endmodule // iwl_host_mem
`default_nettype wire

//--- dv/test_interrupt_status_word_logger.sv
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_status_word_logger;
  logic core_clk = 0, rst = 1, ev_v = 0, en = 1, ld = 0;
  logic [14:0] c = 15'h0000;
  logic [7:0] idx = 8'h00;
  logic [15:0] ptr = 16'h0000, sa = 16'h0100;
  logic [3:0] lag = 4'h0;
  logic mem_ack, mem_req, mem_write, busy, standard_event_pulse;
  logic [15:0] mem_rdata, mem_addr, mem_wdata, log_addr;
  int miscompares = 0, n_tests = 0;
  initial forever #4 core_clk = ~core_clk;
  iwl_logger uut (.core_clk, .rst, .event_valid(ev_v), .event_enabled(en), .record_pointer(ptr),
    .log_start_addr(sa), .log_start_load(ld), .rt_mode(c[14]), .msg_error(c[0]),
    .resp_timeout(c[1]), .sent_status_me(c[2]), .desc_access(c[3]), .valid_cmd_int_en(c[4]),
    .index_zero_int_en(c[5]), .index_after(idx), .mode_code_nodata(c[6]),
    .when_addressed_en(c[7]), .illegal_cmd(c[8]), .broadcast(c[9]), .receive_cmd(c[10]),
    .poll_match(c[11]), .retries_exhausted(c[12]), .int_and_continue(c[13]), .mem_ack,
    .mem_rdata, .mem_req, .mem_write, .mem_addr, .mem_wdata, .busy, .log_addr,
    .standard_event_pulse);
  iwl_host_mem host (.core_clk, .rst, .lag, .mem_req, .mem_write, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata);
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(ref logic s);
    int k;
    k = 0;
    @(negedge core_clk);
    while (s !== 1'b1 && k < 40) begin
      @(negedge core_clk);
      k++;
    end
  endtask
  task ev(input logic [14:0] cv, input logic [7:0] ix, input logic [15:0] exp);
    logic [15:0] a;
    a = log_addr;
    c = cv;
    idx = ix;
    ptr = a ^ 16'h5A5A;
    ev_v = 1;
    @(negedge core_clk);
    ev_v = 0;
    wt(mem_ack);
    chk(mem_wdata, exp);
    chk({busy, mem_write, mem_addr[13:0]}, {2'h3, a[13:0]});
    wt(mem_ack);
    chk(mem_wdata, a ^ 16'h5A5A);
    chk({busy, mem_write, mem_addr[13:0]}, {2'h3, a[13:0] + 14'h0001});
    wt(mem_ack);
    chk({busy, mem_write, mem_addr[13:0]}, {2'h2, a[13:0] + 14'h0002});
    wt(standard_event_pulse);
    chk({15'h0000, standard_event_pulse}, 16'h0001);
    chk(log_addr, a + 16'h0003);
    chk({15'h0000, busy}, 16'h0000);
    @(negedge core_clk);
    chk({15'h0000, standard_event_pulse | mem_req}, 16'h0000);
    chk(host.mem[a[7:0]], exp & 16'hF7FF);
  endtask
  task t_bc;
    lag = 4'h0;
    ev(15'h3FFF, 8'h00, 16'h0C0F);
    ev(15'h0700, 8'h00, 16'h0800);
  endtask
  task t_rt;
    lag = 4'h3;
    ev(15'h7FFF, 8'h00, 16'h0EF2);
    ev(15'h4300, 8'h00, 16'h0810);
  endtask
  task t_idx;
    lag = 4'h1;
    ev(15'h426A, 8'h00, 16'h0880);
    ev(15'h4028, 8'h01, 16'h0800);
  endtask
  task t_off;
    en = 0;
    ev_v = 1;
    @(negedge core_clk);
    ev_v = 0;
    repeat (6) begin
      @(negedge core_clk);
      chk({15'h0000, mem_req}, 16'h0000);
    end
    en = 1;
  endtask
  task close_out;
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    close_out;
  end
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 0;
    chk(log_addr, 16'h0000);
    ld = 1;
    @(negedge core_clk);
    ld = 0;
    @(negedge core_clk);
    chk(log_addr, 16'h0100);
    t_bc;
    t_rt;
    t_idx;
    t_off;
    close_out;
  end
endmodule // test_interrupt_status_word_logger
`default_nettype wire
